// ===== rtl/fht_defs.svh
// Register offsets, field positions, reset values and timing counts of the transmit scheduler
`ifndef FHT_DEFS_SVH
`define FHT_DEFS_SVH
`define FHT_ADR_CTRL 8'h00
`define FHT_ADR_CYCLE_TIME_SETTING 8'h04
`define FHT_ADR_OFS 8'h08
`define FHT_ADR_DATA 8'h0C
`define FHT_ADR_LEN 8'h10
`define FHT_ADR_CFG 8'h14
`define FHT_ADR_SYNC 8'h18
`define FHT_ADR_STAT 8'h1C
`define FHT_CTRL_CRC 0
`define FHT_CTRL_SINT 1
`define FHT_CTRL_SPIN 2
`define FHT_CTRL_RST 3
`define FHT_CTRL_SKIP 4
`define FHT_LEN_RX_LSB 8
`define FHT_CFG_GAP_LSB 4
`define FHT_CFG_RX_THRESHOLD_LEVEL_LSB 8
`define FHT_CYCLE_TIME_SETTING_RST 16'h0000
`define FHT_OFS_RST 16'h0000
`define FHT_TXLEN_RST 7'h02
`define FHT_RXLEN_RST 7'h02
`define FHT_BUF_DEPTH 66
`define FHT_CLK_NS 50
`define FHT_BIT_NS 4340
`define FHT_BIT_CYCLES ((`FHT_BIT_NS) / (`FHT_CLK_NS))
`define FHT_T1_MAX_BITS 1
`define FHT_T2_MAX_BITS 3
`define FHT_TA_MAX_BITS 10
`endif

// ===== rtl/fht_pkg.sv
// Types shared by the transmit scheduler and its bench
package fht_pkg;
  typedef enum logic [1:0] {FHT_IDLE, FHT_TX, FHT_RX, FHT_DONE} fht_state_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } fht_wb_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fht_tx_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic par_err;
    logic cks_err;
  } fht_rx_t;
endpackage

// ===== rtl/fht_sched.sv
// Per-channel master message scheduler with frame buffer, timers and response supervision
`timescale 1ns/100ps
`include "fht_defs.svh"
module fht_sched #(
  parameter int DEPTH = `FHT_BUF_DEPTH,
  parameter int BIT_CYCLES = `FHT_BIT_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire fht_pkg::fht_wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic sync_pin_i,
  output fht_pkg::fht_tx_t tx_o,
  input wire logic tx_done_i,
  input wire fht_pkg::fht_rx_t rx_i,
  output logic [1:0] state_o,
  output logic status_err_o,
  output logic timeout_o,
  output logic rx_level_o
);
  localparam int PW = $clog2(DEPTH + 1);

  typedef struct packed {
    fht_pkg::fht_state_t st;
    logic [DEPTH-1:0][7:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic crc;
    logic sint;
    logic spin;
    logic [15:0] cycle_time_setting;
    logic [15:0] ofs;
    logic [6:0] txlen;
    logic [6:0] rxlen;
    logic [6:0] rx_threshold_level;
    logic [3:0] rsp_rlx;
    logic [3:0] gap_rlx;
    logic err;
    logic tout;
    logic lvl;
    logic ack;
    logic [31:0] dat;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [15:0] bcnt;
    logic [7:0] gap;
    logic rx_any;
    logic s1;
    logic s2;
    logic s3;
    logic slvl;
  } fht_main_t;

  fht_main_t q;
  fht_main_t d;
  logic take;
  logic wr_ctrl;
  logic rst_hit;
  logic skip_hit;
  logic sync_sw;
  logic pin_rise;
  logic tick;
  logic idle;
  logic avail;
  logic sync_en;
  logic cyc_on;
  logic sync_ev;
  logic accept;
  logic go;
  logic cyc_start;
  logic ofs_start;
  logic cyc_run;
  logic cyc_exp;
  logic ofs_run;
  logic ofs_exp;
  logic [7:0] gap_lim;

  // Byte-lane merge of a 16-bit register field
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] sel);
    wr16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Bus request decode; the request is taken once, in the cycle before ack
  assign take = wb_i.cyc && wb_i.stb && !q.ack;
  assign wr_ctrl = take && wb_i.we && wb_i.sel[0] && (wb_i.adr == `FHT_ADR_CTRL);
  assign rst_hit = wr_ctrl && wb_i.dat[`FHT_CTRL_RST];
  assign skip_hit = wr_ctrl && wb_i.dat[`FHT_CTRL_SKIP] && !rst_hit;
  assign sync_sw = take && wb_i.we && wb_i.sel[0] && (wb_i.adr == `FHT_ADR_SYNC) && wb_i.dat[0];
  assign tick = (q.bcnt == 16'(BIT_CYCLES - 1));
  // Pin edge counts only when the last two stages agree
  assign pin_rise = q.s2 && q.s3 && !q.slvl;

  // Start conditions
  assign idle = (q.st == fht_pkg::FHT_IDLE);
  assign avail = q.crc ? (q.wptr == PW'(q.txlen)) : (q.wptr != '0);
  assign sync_en = q.sint || q.spin;
  assign cyc_on = (q.cycle_time_setting != 16'h0000);
  assign sync_ev = (q.sint && sync_sw) || (q.spin && pin_rise);
  // Sync is taken only when idle and neither timer already owns the cycle
  assign accept = sync_en && sync_ev && idle && !ofs_run && !(cyc_on && cyc_run);

  // Transmit decision per mode; an expiry with no data just lets the timer lapse, except a cycle expiry under sync, which reloads both timers
  always_comb begin
    go = 1'b0;
    cyc_start = 1'b0;
    ofs_start = 1'b0;
    if (!sync_en) begin
      go = idle && avail && (!cyc_on || !cyc_run || cyc_exp);
      cyc_start = cyc_on && go;
    end else begin
      ofs_start = accept || (cyc_on && cyc_exp);
      cyc_start = cyc_on && (accept || cyc_exp);
      go = ofs_exp && idle && avail;
    end
  end

  fht_timer #(
    .W(16)
  ) u_cycle (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(cyc_start),
    .stop_i(rst_hit || !cyc_on),
    .tick_i(tick),
    .period_i(q.cycle_time_setting),
    .running_o(cyc_run),
    .expire_o(cyc_exp)
  );

  fht_timer #(
    .W(16)
  ) u_offset (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(ofs_start),
    .stop_i(rst_hit || skip_hit),
    .tick_i(tick),
    .period_i(q.ofs),
    .running_o(ofs_run),
    .expire_o(ofs_exp)
  );

  // Gap limit depends on what the line is waiting for
  always_comb begin
    if (q.st == fht_pkg::FHT_TX) begin
      gap_lim = 8'(`FHT_T1_MAX_BITS);
    end else if (!q.rx_any) begin
      gap_lim = {4'h0, q.rsp_rlx} + 8'(`FHT_TA_MAX_BITS);
    end else begin
      gap_lim = {4'h0, q.gap_rlx} + 8'(`FHT_T2_MAX_BITS);
    end
  end

  // Next state of the whole block
  always_comb begin
    d = q;
    d.ack = take;
    d.bcnt = tick ? 16'h0000 : q.bcnt + 16'h0001;
    d.s1 = sync_pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.slvl = q.s2;
    end
    // Register writes
    if (take && wb_i.we) begin
      case (wb_i.adr)
        `FHT_ADR_CTRL: begin
          if (wb_i.sel[0]) begin
            d.crc = wb_i.dat[`FHT_CTRL_CRC];
            d.sint = wb_i.dat[`FHT_CTRL_SINT];
            d.spin = wb_i.dat[`FHT_CTRL_SPIN];
          end
        end
        `FHT_ADR_CYCLE_TIME_SETTING: d.cycle_time_setting = wr16(q.cycle_time_setting, wb_i.dat, wb_i.sel);
        `FHT_ADR_OFS: d.ofs = wr16(q.ofs, wb_i.dat, wb_i.sel);
        `FHT_ADR_LEN: begin
          if (wb_i.sel[0]) begin
            d.txlen = wb_i.dat[6:0];
          end
          if (wb_i.sel[1]) begin
            d.rxlen = wb_i.dat[`FHT_LEN_RX_LSB +: 7];
          end
        end
        `FHT_ADR_CFG: begin
          if (wb_i.sel[0]) begin
            d.rsp_rlx = wb_i.dat[3:0];
            d.gap_rlx = wb_i.dat[`FHT_CFG_GAP_LSB +: 4];
          end
          if (wb_i.sel[1]) begin
            d.rx_threshold_level = wb_i.dat[`FHT_CFG_RX_THRESHOLD_LEVEL_LSB +: 7];
          end
        end
        `FHT_ADR_DATA: begin
          // Master bytes append until the message length is reached; others are ignored
          if (wb_i.sel[0] && (idle || q.st == fht_pkg::FHT_TX) && q.wptr < PW'(q.txlen)
              && q.wptr < PW'(DEPTH)) begin
            d.mem[q.wptr] = wb_i.dat[7:0];
            d.wptr = q.wptr + 1'b1;
          end
        end
        default: d.dat = q.dat;
      endcase
    end
    // Register reads; unmapped offsets read zero
    if (take && !wb_i.we) begin
      case (wb_i.adr)
        `FHT_ADR_CTRL: d.dat = {29'h0000_0000, q.spin, q.sint, q.crc};
        `FHT_ADR_CYCLE_TIME_SETTING: d.dat = {16'h0000, q.cycle_time_setting};
        `FHT_ADR_OFS: d.dat = {16'h0000, q.ofs};
        `FHT_ADR_LEN: d.dat = {17'h0_0000, q.rxlen, 1'b0, q.txlen};
        `FHT_ADR_CFG: d.dat = {17'h0_0000, q.rx_threshold_level, q.gap_rlx, q.rsp_rlx};
        `FHT_ADR_STAT: d.dat = {16'h0000, 8'(q.wptr), 3'h0, q.lvl, q.tout, q.err, q.st};
        `FHT_ADR_DATA: begin
          d.dat = 32'h0000_0000;
          // Response bytes pop in order; the last one frees the buffer
          if (q.st == fht_pkg::FHT_DONE && q.rptr < q.wptr) begin
            d.dat = {24'h00_0000, q.mem[q.rptr]};
            d.rptr = q.rptr + 1'b1;
            if (PW'(q.rptr + 1'b1) == q.wptr) begin
              d.st = fht_pkg::FHT_IDLE;
              d.wptr = '0;
              d.rptr = '0;
              d.lvl = 1'b0;
            end
          end
        end
        default: d.dat = 32'h0000_0000;
      endcase
    end
    // Gap timer in bit ticks, held at zero while a byte is on the line
    if (q.st == fht_pkg::FHT_TX || q.st == fht_pkg::FHT_RX) begin
      if (q.tx_valid) begin
        d.gap = 8'h00;
      end else if (tick && q.gap != 8'hFF) begin
        d.gap = q.gap + 8'h01;
      end
      if (q.gap > gap_lim && !(q.st == fht_pkg::FHT_TX && q.rptr == '0)) begin
        d.tout = 1'b1;
      end
    end
    // Start of a master message clears the previous verdict
    if (go) begin
      d.st = fht_pkg::FHT_TX;
      d.rptr = '0;
      d.gap = 8'h00;
      d.err = 1'b0;
      d.tout = 1'b0;
      d.lvl = 1'b0;
      d.rx_any = 1'b0;
    end
    // A byte leaves the line; after the last one the buffer turns to receive
    if (q.st == fht_pkg::FHT_TX && q.tx_valid && tx_done_i) begin
      d.rptr = q.rptr + 1'b1;
      d.gap = 8'h00;
      if (PW'(q.rptr + 1'b1) >= PW'(q.txlen)) begin
        d.st = fht_pkg::FHT_RX;
        d.wptr = '0;
        d.rptr = '0;
      end
    end
    // Response bytes are stored even when faulty
    if (q.st == fht_pkg::FHT_RX && rx_i.valid && q.wptr < PW'(q.rxlen) && q.wptr < PW'(DEPTH)) begin
      d.mem[q.wptr] = rx_i.data;
      d.wptr = q.wptr + 1'b1;
      d.rx_any = 1'b1;
      d.gap = 8'h00;
      if (rx_i.par_err) begin
        d.err = 1'b1;
      end
      if (PW'(q.wptr + 1'b1) == PW'(q.rx_threshold_level)) begin
        d.lvl = 1'b1;
      end
      if (PW'(q.wptr + 1'b1) == PW'(q.rxlen)) begin
        d.st = fht_pkg::FHT_DONE;
        d.lvl = 1'b1;
        if (rx_i.cks_err) begin
          d.err = 1'b1;
        end
      end
    end
    // Abort wins over the state, pointer, gap and level updates of the cycle
    if (rst_hit || skip_hit) begin
      d.st = fht_pkg::FHT_IDLE;
      d.wptr = '0;
      d.rptr = '0;
      d.gap = 8'h00;
      d.lvl = 1'b0;
    end
    // Line request follows the buffer: only while sending and a byte is present
    d.tx_valid = (d.st == fht_pkg::FHT_TX) && (d.rptr < d.wptr) && !(q.tx_valid && tx_done_i);
    d.tx_data = d.mem[d.rptr];
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cycle_time_setting <= `FHT_CYCLE_TIME_SETTING_RST;
      q.ofs <= `FHT_OFS_RST;
      q.txlen <= `FHT_TXLEN_RST;
      q.rxlen <= `FHT_RXLEN_RST;
    end else begin
      q <= d;
    end
  end

  // All outputs straight from flops
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign tx_o.valid = q.tx_valid;
  assign tx_o.data = q.tx_data;
  assign state_o = q.st;
  assign status_err_o = q.err;
  assign timeout_o = q.tout;
  assign rx_level_o = q.lvl;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_crc_full_msg: assert property (
    (q.st == fht_pkg::FHT_IDLE && d.st == fht_pkg::FHT_TX && q.crc) |-> (q.wptr == PW'(q.txlen)))
    else $error("Checksum mode started before the message was complete");
  a_nocrc_one_byte: assert property (
    (q.st == fht_pkg::FHT_IDLE && d.st == fht_pkg::FHT_TX) |-> (q.wptr != '0))
    else $error("Transmission started with an empty buffer");
  a_tx_only_sending: assert property (
    (q.st != fht_pkg::FHT_TX) |-> !tx_o.valid)
    else $error("Line request outside the sending state");
  a_sync_busy_ignored: assert property (
    (q.st != fht_pkg::FHT_IDLE && !cyc_on && !ofs_run) |=> !ofs_run)
    else $error("Offset timer started while busy");
  a_abort_idle: assert property (
    (rst_hit || skip_hit) |=> (q.st == fht_pkg::FHT_IDLE && q.wptr == '0 && !tx_o.valid))
    else $error("Abort did not return to idle with an empty buffer");
  a_cycle_off_stops: assert property (
    (q.cycle_time_setting == 16'h0000) [*2] |-> !cyc_run)
    else $error("Cycle timer runs with zero setting");
  a_fault_stored: assert property (
    (q.st == fht_pkg::FHT_RX && rx_i.valid && rx_i.par_err && q.wptr < PW'(q.rxlen) && !rst_hit && !skip_hit)
    |=> (q.err && q.wptr == $past(q.wptr) + 1'b1))
    else $error("Faulty response byte not stored or not flagged");
  a_resp_timeout: assert property (
    (q.st == fht_pkg::FHT_RX && !q.rx_any && q.gap > gap_lim && !go) |=> timeout_o)
    else $error("Response time exceeded without timeout flag");
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Bus ack held longer than one cycle");
  a_skip_keeps_cycle: assert property (
    (skip_hit && cyc_run && cyc_on && !cyc_exp) |=> cyc_run)
    else $error("Skip disturbed the cycle timer");
endmodule // fht_sched

// ===== rtl/fht_timer.sv
// Reloadable down counter used for the cycle and offset timers
`timescale 1ns/100ps
module fht_timer #(
  parameter int W = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic tick_i,
  input wire logic [W-1:0] period_i,
  output logic running_o,
  output logic expire_o
);
  typedef struct packed {
    logic run;
    logic [W-1:0] cnt;
  } fht_tmr_t;
  fht_tmr_t q;
  fht_tmr_t d;

  // Period is latched on start, so a new setting waits for the next reload
  always_comb begin
    d = q;
    if (stop_i) begin
      d.run = 1'b0;
    end else if (start_i) begin
      d.run = 1'b1;
      d.cnt = period_i;
    end else if (q.run) begin
      if (q.cnt == '0) begin
        d.run = 1'b0;
      end else if (tick_i) begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Expiry is seen in the cycle the count runs out; zero period fires right after start
  assign running_o = q.run;
  assign expire_o = q.run && (q.cnt == '0);

  a_zero_period: assert property (@(posedge clock_i) disable iff (rst_i)
    (start_i && !stop_i && period_i == '0) |=> expire_o)
    else $error("Zero period did not expire on the next cycle");
endmodule // fht_timer

// ===== verif/fht_dev_model.sv
// Behavioural device on the far side of the line: takes master bytes, then replies
`timescale 1ns/100ps
module fht_dev_model #(
  parameter int FRAME = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire fht_pkg::fht_tx_t tx_i,
  input wire logic [6:0] tx_len_i,
  input wire logic [6:0] rx_len_i,
  input wire logic [7:0] gap_i,
  input wire logic par_bad_i,
  output logic tx_done_o,
  output fht_pkg::fht_rx_t rx_o
);
  int cnt;
  int nb;
  int nr;
  logic [7:0] last;
  // One frame time per master byte, then the reply after a chosen gap
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      nb <= 0;
      nr <= -1;
      last <= 8'h00;
      tx_done_o <= 1'b0;
      rx_o <= '{1'b0, 8'hFF, 1'b0, 1'b0};
    end else begin
      tx_done_o <= 1'b0;
      // Idle line shows the inverse of the last byte, never a stale copy
      rx_o <= '{1'b0, ~last, 1'b0, 1'b0};
      if (nr >= 0) begin
        cnt <= cnt + 1;
        if (cnt == ((nr == 0) ? int'(gap_i) : FRAME)) begin
          rx_o <= '{1'b1, 8'hA0 + nr[7:0], par_bad_i && (nr == 0), 1'b0};
          last <= 8'hA0 + nr[7:0];
          cnt <= 1;
          nr <= (nr + 1 == int'(rx_len_i)) ? -1 : nr + 1;
        end
      end else if (tx_i.valid && !tx_done_o) begin
        cnt <= cnt + 1;
        if (cnt == FRAME) begin
          tx_done_o <= 1'b1;
          cnt <= 0;
          nb <= (nb + 1 == int'(tx_len_i)) ? 0 : nb + 1;
          if (nb + 1 == int'(tx_len_i)) begin
            nr <= 0;
            cnt <= 1;
          end
        end
      end
    end
  end
endmodule // fht_dev_model

// ===== verif/frame_handler_tx_scheduler_bench.sv
// Self-checking bench of the transmit scheduler with a device model on the line
`timescale 1ns/100ps
`include "fht_defs.svh"
module frame_handler_tx_scheduler_bench;
  logic clock_i, rst_i, wb_ack_o, sync_pin_i, tx_done_i, status_err_o, timeout_o, rx_level_o, par_bad;
  logic [31:0] wb_dat_o;
  logic [1:0] state_o;
  logic [6:0] mtx, mrx;
  logic [7:0] gap, lfsr_q;
  logic [63:0] e;
  fht_pkg::fht_wb_req_t wb_i;
  fht_pkg::fht_tx_t tx_o;
  fht_pkg::fht_rx_t rx_i;
  int errors, check_count;
  logic [7:0] txq[$];
  logic [63:0] rdq[$];
  fht_sched #(.BIT_CYCLES(4)) dut (.clock_i(clock_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .sync_pin_i(sync_pin_i), .tx_o(tx_o), .tx_done_i(tx_done_i), .rx_i(rx_i),
    .state_o(state_o), .status_err_o(status_err_o), .timeout_o(timeout_o), .rx_level_o(rx_level_o));
  fht_dev_model partner (.clock_i(clock_i), .rst_i(rst_i), .tx_i(tx_o), .tx_len_i(mtx), .rx_len_i(mrx),
    .gap_i(gap), .par_bad_i(par_bad), .tx_done_o(tx_done_i), .rx_o(rx_i));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic cycle: hold the request until ack is seen at an edge, then release
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clock_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h3, dat: dat};
    do begin
      @(posedge clock_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    // Judge by ack itself, so an answer seen on the last allowed edge still counts
    if (wb_ack_o !== 1'b1) begin
      cmp_word("bus ack", 32'h0000_0001, 32'h0000_0000);
      results();
    end else wb_i <= '0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_cycle(1'b1, adr, dat);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask);
    rdq.push_back({mask, exp});
    wb_cycle(1'b0, adr, 32'h0000_0000);
  endtask
  task automatic set_len(input logic [6:0] t, input logic [6:0] r);
    wr(`FHT_ADR_LEN, {17'h0_0000, r, 1'b0, t});
    mtx <= t;
    mrx <= r;
  endtask
  task automatic send_msg(input int n, input logic keep);
    for (int k = 0; k < n; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      if (keep) txq.push_back(lfsr_q);
      wr(`FHT_ADR_DATA, {24'h00_0000, lfsr_q});
    end
  endtask
  task automatic wait_state(input logic [1:0] s, input int bound);
    int n;
    n = 0;
    while (state_o !== s && n < bound) begin
      @(posedge clock_i);
      n++;
    end
    if (state_o !== s) begin
      cmp_word("state", {30'h0, s}, {30'h0, state_o});
      results();
    end
  endtask
  task automatic idle_for(input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge clock_i);
      if (state_o !== 2'h0 || tx_o.valid !== 1'b0) bad++;
    end
    cmp_word("held idle", 32'h0000_0000, bad);
  endtask
  // Reply ready: flags, stored bytes in order, then back to idle
  task automatic finish_msg(input int nrx);
    wait_state(2'h3, 600);
    cmp_word("error flag", {31'h0, par_bad}, {31'h0, status_err_o});
    cmp_word("level flag", 32'h0000_0001, {31'h0, rx_level_o});
    for (int k = 0; k < nrx; k++) rd(`FHT_ADR_DATA, 32'h0000_00A0 + k, 32'h0000_00FF);
    wait_state(2'h0, 20);
    cmp_word("level cleared", 32'h0000_0000, {31'h0, rx_level_o});
  endtask
  // Watcher: line bytes and read data against the oldest notes
  always @(posedge clock_i) begin
    if (wb_ack_o === 1'b1 && wb_i.we === 1'b0 && rdq.size() > 0) begin
      e = rdq.pop_front();
      cmp_word("bus read", e[31:0] & e[63:32], wb_dat_o & e[63:32]);
    end
    if (tx_o.valid === 1'b1 && tx_done_i === 1'b1) begin
      if (txq.size() > 0) cmp_byte("line byte", txq.pop_front(), tx_o.data);
      else cmp_word("unexpected line byte", 32'h0000_0000, 32'h0000_0001);
    end
  end
  initial begin
    errors = 0;
    check_count = 0;
    rst_i = 1'b1;
    wb_i = '0;
    sync_pin_i = 1'b0;
    par_bad = 1'b0;
    gap = 8'h08;
    mtx = 7'h02;
    mrx = 7'h02;
    lfsr_q = 8'h32;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    // Reset values, plus an unmapped address that must still be acked
    rd(`FHT_ADR_CTRL, 32'h0000_0000, 32'h0000_0007);
    rd(`FHT_ADR_CYCLE_TIME_SETTING, 32'h0000_0000, 32'h0000_FFFF);
    rd(`FHT_ADR_OFS, 32'h0000_0000, 32'h0000_FFFF);
    rd(`FHT_ADR_LEN, 32'h0000_0202, 32'h0000_7F7F);
    rd(`FHT_ADR_CFG, 32'h0000_0000, 32'h0000_7FFF);
    rd(8'h24, 32'h0000_0000, 32'hFFFF_FFFF);
    // All modes off; a write while the reply waits is dropped
    send_msg(2, 1'b1);
    wait_state(2'h3, 600);
    wr(`FHT_ADR_DATA, 32'h0000_0055);
    finish_msg(2);
    // Checksum mode holds a partial message back
    wr(`FHT_ADR_CTRL, 32'h0000_0001);
    set_len(7'h03, 7'h02);
    send_msg(2, 1'b1);
    idle_for(40);
    send_msg(1, 1'b1);
    finish_msg(2);
    // Parity fault is flagged, reply still stored; next start clears it
    par_bad <= 1'b1;
    send_msg(3, 1'b1);
    finish_msg(2);
    par_bad <= 1'b0;
    send_msg(3, 1'b1);
    finish_msg(2);
    // Late reply: timeout without relax, none with the widest relax
    gap <= 8'h3C;
    for (int r = 0; r < 2; r++) begin
      wr(`FHT_ADR_CFG, (r == 1) ? 32'h0000_000F : 32'h0000_0000);
      send_msg(3, 1'b1);
      repeat (200) @(posedge clock_i);
      cmp_word("timeout flag", (r == 1) ? 32'h0000_0000 : 32'h0000_0001, {31'h0, timeout_o});
      if (r == 0) begin
        wr(`FHT_ADR_CTRL, 32'h0000_0011);
        wait_state(2'h0, 20);
      end else finish_msg(2);
    end
    gap <= 8'h08;
    wr(`FHT_ADR_CFG, 32'h0000_0000);
    // Skip throws away a partial message
    send_msg(1, 1'b0);
    rd(`FHT_ADR_STAT, 32'h0000_0100, 32'h0000_FF03);
    wr(`FHT_ADR_CTRL, 32'h0000_0011);
    rd(`FHT_ADR_STAT, 32'h0000_0000, 32'h0000_FF03);
    send_msg(3, 1'b1);
    finish_msg(2);
    // Software sync: empty-buffer expiry is silent, data waits for sync
    wr(`FHT_ADR_CTRL, 32'h0000_0002);
    wr(`FHT_ADR_OFS, 32'h0000_0003);
    set_len(7'h02, 7'h02);
    wr(`FHT_ADR_SYNC, 32'h0000_0001);
    idle_for(40);
    cmp_word("no fault", 32'h0000_0000, {30'h0, status_err_o, timeout_o});
    send_msg(2, 1'b1);
    idle_for(40);
    wr(`FHT_ADR_SYNC, 32'h0000_0001);
    finish_msg(2);
    // Pin sync
    wr(`FHT_ADR_CTRL, 32'h0000_0004);
    // Zero offset: the send follows the pin edge on the next cycle
    wr(`FHT_ADR_OFS, 32'h0000_0000);
    send_msg(2, 1'b1);
    idle_for(20);
    sync_pin_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    sync_pin_i <= 1'b0;
    finish_msg(2);
    // Cycle timer: the next message waits for expiry, 80 ticks of 4 clocks
    wr(`FHT_ADR_CTRL, 32'h0000_0000);
    wr(`FHT_ADR_CYCLE_TIME_SETTING, 32'h0000_0050);
    send_msg(2, 1'b1);
    finish_msg(2);
    send_msg(2, 1'b1);
    idle_for(100);
    finish_msg(2);
    wr(`FHT_ADR_CYCLE_TIME_SETTING, 32'h0000_0000);
    // Sync plus cycle: first sync starts both timers, a partial level flag shows mid-reply
    wr(`FHT_ADR_CTRL, 32'h0000_0002);
    wr(`FHT_ADR_OFS, 32'h0000_0003);
    wr(`FHT_ADR_CYCLE_TIME_SETTING, 32'h0000_0050);
    wr(`FHT_ADR_CFG, 32'h0000_0100);
    send_msg(2, 1'b1);
    wr(`FHT_ADR_SYNC, 32'h0000_0001);
    wait_state(2'h2, 600);
    for (int n = 0; n < 600 && rx_level_o !== 1'b1; n++) @(posedge clock_i);
    cmp_word("level before end", 32'h0000_0002, {30'h0, state_o});
    finish_msg(2);
    // A sync while the cycle timer runs must not pull the next send forward
    send_msg(2, 1'b1);
    wr(`FHT_ADR_SYNC, 32'h0000_0001);
    idle_for(100);
    finish_msg(2);
    wr(`FHT_ADR_CYCLE_TIME_SETTING, 32'h0000_0000);
    wr(`FHT_ADR_CFG, 32'h0000_0000);
    cmp_word("bytes left", 32'h0000_0000, txq.size());
    results();
  end
endmodule // frame_handler_tx_scheduler_bench
